// >>> hw/gdt_pkg.sv
// Package with constants and carrier types of the guard timer.
// Summary of operation
// - Sixteen-bit downcounter; reload is high byte over low byte.
// - Counter advances only on oscillator ticks; oscillator enable cleared stops counting.
// - Two states, off and on; once on, counts until device reset.
// - Refresh instruction enables it; always-on option at 0 also runs it.
// - Timeout in milliseconds is reload value divided by ten at 10 kHz.
// - Reload resets to 0400h; FFFFh gives the longest timeout.
// - On first enable load counter from reload, then decrement toward 0000h.
// - Each refresh reloads the counter; counting resumes from reload.
// - Debug mode refreshes the counter continuously, so no timeout.
// - Timeout at 0000h; response select picks exception or device reset.
// - Exception response in normal mode: exception request, auto reload, keep counting.
// - Exception response in stop mode: stop recovery, exception, status and stop bits set.
// - Reset response in normal mode: device reset, status bit set, counter reinitialised.
// - Reset response in stop mode: stop recovery instead of reset, both bits set.
// - Writing 55h then AAh to high byte unlocks; neither changes high byte.
// - Then high byte write, then low byte write; low byte write relocks.
// - Writes to reload registers while locked are ignored.
// - Reads of high and low byte addresses return the current count.
package gdt_pkg;

	localparam logic [11:0] GDT_ADDR_HIGH = 12'hff2;
	localparam logic [11:0] GDT_ADDR_LOW = 12'hff3;
	localparam logic [15:0] GDT_RELOAD_RESET = 16'h0400;
	localparam logic [15:0] GDT_COUNT_ZERO = 16'h0000;
	localparam logic [7:0] GDT_KEY_FIRST = 8'h55;
	localparam logic [7:0] GDT_KEY_SECOND = 8'haa;
	localparam logic [7:0] GDT_BYTE_ZERO = 8'h00;
	localparam int GDT_CLK_HZ = 25000000;
	localparam int GDT_OSC_HZ = 10000;
	localparam int GDT_OSC_DIV = GDT_CLK_HZ / GDT_OSC_HZ;

	typedef enum logic {GDT_RESP_EXCEPTION, GDT_RESP_RESET} gdt_resp_t;

	typedef enum {GDT_LOCKED, GDT_KEY1_SEEN, GDT_OPEN_HIGH, GDT_OPEN_LOW} gdt_lock_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} gdt_bus_t;

	typedef struct packed {
		logic always_on_option;
		gdt_resp_t timeout_response_select;
	} gdt_opt_t;

	typedef struct packed {
		logic exception_req;
		logic device_reset_req;
		logic stop_recovery_req;
	} gdt_evt_t;

endpackage

// >>> hw/gdt_osc_tick.sv
// Tick generator standing in for the dedicated guard oscillator.
`timescale 1ns/1ps
module gdt_osc_tick #(
	parameter int DIV = gdt_pkg::GDT_OSC_DIV
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Oscillator enable and tick.
	input wire logic enable,
	output logic tick
);
	import gdt_pkg::*;

	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] count;

	// A stopped oscillator holds its phase and gives no ticks.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			tick <= 1'b0;
		end else if (!enable) begin
			tick <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + CW'(1);
			tick <= 1'b0;
		end
	end
endmodule // gdt_osc_tick

// >>> hw/gdt_unlock.sv
// Unlock sequencer for the reload byte registers.
`timescale 1ns/1ps
module gdt_unlock (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Register writes from the bus.
	input wire logic wr_high,
	input wire logic wr_low,
	input wire logic [7:0] wdata,
	// Write permissions granted this cycle.
	output logic store_high,
	output logic store_low,
	output logic unlocked
);
	import gdt_pkg::*;

	gdt_lock_t state;

	assign store_high = wr_high && state == GDT_OPEN_HIGH;
	assign store_low = wr_low && state == GDT_OPEN_LOW;
	assign unlocked = state == GDT_OPEN_HIGH || state == GDT_OPEN_LOW;

	// An out-of-order write drops the sequence back to locked.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= GDT_LOCKED;
		end else if (wr_high || wr_low) begin
			unique case (state)
				GDT_LOCKED: begin
					state <= (wr_high && wdata == GDT_KEY_FIRST) ? GDT_KEY1_SEEN : GDT_LOCKED;
				end
				GDT_KEY1_SEEN: begin
					state <= (wr_high && wdata == GDT_KEY_SECOND) ? GDT_OPEN_HIGH : GDT_LOCKED;
				end
				GDT_OPEN_HIGH: begin
					state <= wr_high ? GDT_OPEN_LOW : GDT_LOCKED;
				end
				GDT_OPEN_LOW: begin
					state <= GDT_LOCKED;
				end
			endcase
		end
	end
endmodule // gdt_unlock

// >>> hw/gdt_guard_timer.sv
// Guard timer top: reload registers, downcounter and timeout response.
`timescale 1ns/1ps
module gdt_guard_timer #(
	parameter int OSC_DIV = gdt_pkg::GDT_OSC_DIV
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Register port.
	input wire gdt_pkg::gdt_bus_t bus,
	output logic [7:0] rdata,
	// CPU status and option bits.
	input wire logic refresh_instr,
	input wire logic debug_mode,
	input wire logic stop_mode,
	input wire logic guard_osc_enable,
	input wire gdt_pkg::gdt_opt_t opts,
	// Timeout outputs and status.
	output gdt_pkg::gdt_evt_t events,
	output logic guard_status,
	output logic stop_status,
	output logic running,
	output logic [15:0] count
);
	import gdt_pkg::*;

	logic tick;
	logic store_high;
	logic store_low;
	logic [7:0] reload_high_byte;
	logic [7:0] reload_low_byte;
	logic [15:0] reload;
	logic refresh;
	logic enable_now;
	logic timeout;

	gdt_osc_tick #(.DIV(OSC_DIV)) u_osc (
		.clk(clk),
		.reset_n(reset_n),
		.enable(guard_osc_enable),
		.tick(tick)
	);

	gdt_unlock u_unlock (
		.clk(clk),
		.reset_n(reset_n),
		.wr_high(bus.wr && bus.addr == GDT_ADDR_HIGH),
		.wr_low(bus.wr && bus.addr == GDT_ADDR_LOW),
		.wdata(bus.wdata),
		.store_high(store_high),
		.store_low(store_low),
		.unlocked()
	);

	assign reload = {reload_high_byte, reload_low_byte};
	assign refresh = refresh_instr || debug_mode;
	assign enable_now = refresh_instr || !opts.always_on_option;
	assign timeout = running && tick && count == GDT_COUNT_ZERO;

	// Key writes never reach the byte registers; only granted writes store.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reload_high_byte <= GDT_RELOAD_RESET[15:8];
			reload_low_byte <= GDT_RELOAD_RESET[7:0];
		end else begin
			if (store_high) begin
				reload_high_byte <= bus.wdata;
			end
			if (store_low) begin
				reload_low_byte <= bus.wdata;
			end
		end
	end

	// Once on, only the device reset turns the timer off again.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			running <= 1'b0;
		end else if (enable_now) begin
			running <= 1'b1;
		end
	end

	// One count per oscillator tick, so the period is reload over ten in ms.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= GDT_RELOAD_RESET;
		end else if (!running) begin
			count <= reload;
		end else if (refresh || timeout) begin
			count <= reload;
		end else if (tick) begin
			count <= count - 16'h0001;
		end
	end

	// Requests are one-cycle pulses; the reset logic outside acts on them.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			events <= '0;
		end else begin
			events.exception_req <= timeout && !debug_mode &&
				opts.timeout_response_select == GDT_RESP_EXCEPTION;
			events.device_reset_req <= timeout && !debug_mode && !stop_mode &&
				opts.timeout_response_select == GDT_RESP_RESET;
			events.stop_recovery_req <= timeout && !debug_mode && stop_mode;
		end
	end

	// Status bits are sticky until the device reset clears them.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			guard_status <= 1'b0;
			stop_status <= 1'b0;
		end else if (timeout && !debug_mode) begin
			guard_status <= 1'b1;
			if (stop_mode) begin
				stop_status <= 1'b1;
			end
		end
	end

	// Reads return the live count, not the stored reload value.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= GDT_BYTE_ZERO;
		end else if (bus.rd && bus.addr == GDT_ADDR_HIGH) begin
			rdata <= count[15:8];
		end else if (bus.rd && bus.addr == GDT_ADDR_LOW) begin
			rdata <= count[7:0];
		end else begin
			rdata <= GDT_BYTE_ZERO;
		end
	end
endmodule // gdt_guard_timer

// >>> tb/gdt_reset_model.sv
// Reset logic model that answers a device reset request.
`timescale 1ns/1ps
module gdt_reset_model (
	// Clock and request.
	input wire logic clk,
	input wire logic req,
	// Reset output, low while the device is held.
	output logic rst_n
);
	logic [1:0] hold = 2'h0;
	assign rst_n = (hold == 2'h0);
	always @(posedge clk) begin
		if (req) begin
			hold <= 2'h3;
		end else if (hold != 2'h0) begin
			hold <= hold - 2'h1;
		end
	end
endmodule // gdt_reset_model

// >>> tb/gdt_monitor.sv
// Concurrent checks on the guard timer ports.
`timescale 1ns/1ps
module gdt_monitor (
	// Ports of the guard timer.
	input wire logic clk,
	input wire logic reset_n,
	input wire gdt_pkg::gdt_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic refresh_instr,
	input wire logic debug_mode,
	input wire logic stop_mode,
	input wire logic guard_osc_enable,
	input wire gdt_pkg::gdt_opt_t opts,
	input wire gdt_pkg::gdt_evt_t events,
	input wire logic guard_status,
	input wire logic stop_status,
	input wire logic running,
	input wire logic [15:0] count
);
	import gdt_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Four quiet cycles cover the tick and reload pipeline.
	sequence s_idle;
		(!guard_osc_enable && !refresh_instr && !bus.wr)[*4];
	endsequence
	a_read_live: assert property (
		bus.rd && bus.addr == GDT_ADDR_LOW |=> rdata == 8'($past(count)))
		else $error("low byte read differs from count");
	// Events are registered, so the conditions that caused them lie one sample back.
	a_exc_timeout: assert property (events.exception_req |->
		$past(count) == GDT_COUNT_ZERO &&
		$past(opts.timeout_response_select) == GDT_RESP_EXCEPTION)
		else $error("exception request without timeout");
	a_reset_resp: assert property (events.device_reset_req |->
		!$past(stop_mode) && $past(opts.timeout_response_select) == GDT_RESP_RESET)
		else $error("device reset request in wrong mode");
	a_stop_flags: assert property (events.stop_recovery_req |->
		$past(stop_mode) && guard_status && stop_status)
		else $error("stop recovery without stop and status flags");
	a_debug_quiet: assert property (debug_mode [*3] |-> events == '0)
		else $error("timeout event in debug mode");
	a_osc_freeze: assert property (s_idle |-> $stable(count))
		else $error("count moved with oscillator off");
	a_stays_on: assert property (refresh_instr || running |=> running)
		else $error("timer not on after refresh or dropped");
	a_stays_off: assert property (
		!running && !refresh_instr && opts.always_on_option |=> !running)
		else $error("timer turned on by itself");
endmodule // gdt_monitor
bind gdt_guard_timer gdt_monitor mon_u (.clk(clk), .reset_n(reset_n), .bus(bus),
	.rdata(rdata), .refresh_instr(refresh_instr), .debug_mode(debug_mode),
	.stop_mode(stop_mode), .guard_osc_enable(guard_osc_enable), .opts(opts),
	.events(events), .guard_status(guard_status), .stop_status(stop_status),
	.running(running), .count(count));

// >>> tb/tb.sv
// Self-checking bench for the guard timer.
`timescale 1ns/1ps
module tb;
	import gdt_pkg::*;
	logic clk = 1'b0, por_n = 1'b0, refresh_instr = 1'b0, debug_mode = 1'b0;
	logic stop_mode = 1'b0, osc_en = 1'b1, dev_rst_n, guard_status, stop_status, running;
	gdt_bus_t bus = '0;
	gdt_opt_t opts = '{1'b1, GDT_RESP_EXCEPTION};
	gdt_evt_t events;
	logic [7:0] rdata, rd_val, hi, lo;
	logic [15:0] count;
	int bad_count = 0, tests_run = 0, cyc = 0, n;
	integer seed = 32'h481e22f2;
	gdt_guard_timer #(.OSC_DIV(4)) dut_u (.clk(clk), .reset_n(por_n & dev_rst_n), .bus(bus),
		.rdata(rdata), .refresh_instr(refresh_instr), .debug_mode(debug_mode),
		.stop_mode(stop_mode), .guard_osc_enable(osc_en), .opts(opts), .events(events),
		.guard_status(guard_status), .stop_status(stop_status), .running(running),
		.count(count));
	gdt_reset_model rst_u (.clk(clk), .req(events.device_reset_req), .rst_n(dev_rst_n));
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			$display("ERROR %0t: run limit reached", $time);
			complete_run();
		end
	end
	function automatic logic [15:0] reload_of(input logic [7:0] h, input logic [7:0] l);
		return {h, l};
	endfunction
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Each access leaves one idle cycle so no strobe is assigned twice in a time step.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [11:0] a);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 rd_val = rdata;
		step(1);
	endtask
	task automatic pulse_refresh();
		refresh_instr <= 1'b1;
		step(1);
		refresh_instr <= 1'b0;
	endtask
	// Always advance first, so a pulse that is still showing is not taken twice.
	task automatic wait_for(input int which);
		n = 0;
		do begin
			step(1);
			n = n + 1;
		end while (events[which] !== 1'b1 && n < 2000);
	endtask
	initial begin
		step(4);
		por_n <= 1'b1;
		step(3);
		chk(running, 1'b0);
		chk(count, GDT_RELOAD_RESET);
		hi = GDT_BYTE_ZERO;
		lo = 8'h10 | (8'($random(seed)) & 8'h1f);
		wr(GDT_ADDR_LOW, 8'h77);
		wr(GDT_ADDR_HIGH, GDT_KEY_FIRST);
		wr(GDT_ADDR_HIGH, GDT_KEY_SECOND);
		rd(GDT_ADDR_HIGH);
		chk(rd_val, 8'h04);
		wr(GDT_ADDR_HIGH, hi);
		wr(GDT_ADDR_LOW, lo);
		wr(GDT_ADDR_LOW, 8'hff);
		step(2);
		rd(GDT_ADDR_LOW);
		chk(rd_val, lo);
		chk(count, reload_of(hi, lo));
		for (int i = 0; i < 3; i++) begin
			if (i == 2) step(20);
			if (i != 1) pulse_refresh();
			wait_for(2);
			chk(events, 3'b100);
			chk(16'(n >= 4 * lo && n <= 4 * lo + 16), 16'h1);
		end
		debug_mode <= 1'b1;
		step(600);
		chk(count, reload_of(hi, lo));
		debug_mode <= 1'b0;
		osc_en <= 1'b0;
		pulse_refresh();
		step(100);
		chk(count, reload_of(hi, lo));
		osc_en <= 1'b1;
		stop_mode <= 1'b1;
		wait_for(0);
		chk(events, 3'b101);
		opts.timeout_response_select <= GDT_RESP_RESET;
		step(1);
		chk({guard_status, stop_status}, 2'b11);
		wait_for(0);
		chk(events, 3'b001);
		stop_mode <= 1'b0;
		wait_for(1);
		chk(events, 3'b010);
		step(6);
		chk(count, GDT_RELOAD_RESET);
		chk(running, 1'b0);
		opts <= '{1'b0, GDT_RESP_EXCEPTION};
		por_n <= 1'b0;
		step(1);
		por_n <= 1'b1;
		step(2);
		chk(running, 1'b1);
		complete_run();
	end
endmodule // tb
